// file: ctdc_bench.sv
// Self-checking testbench for the clock, timer and readout display controller.
`timescale 1ns/100ps
`include "ctdc_defs.svh"
module ctdc_bench;
  import ctdc_pkg::*;

  localparam int SEC  = 20;
  localparam int DATE = 30;

  typedef struct {
    int           btn;
    ctdc_upper_t  up;
    ctdc_suffix_t suf;
    logic         ann;
  } ctdc_row_t;

  logic         clk_sys = 1'b0;
  logic         resetn  = 1'b0;
  logic   [3:0] btn;
  ctdc_upper_t  upper_readout;
  ctdc_suffix_t upper_suffix;
  logic   [6:0] lower_left;
  logic   [6:0] lower_right;
  logic         lower_left_lit;
  logic         lower_right_lit;
  logic         timer_annunciator;
  logic         clock_running;
  logic         left_dark;
  logic         right_dark;
  int           fails     = 0;
  int           cmp_count = 0;

  ctdc_row_t rows [5] = '{
    '{`CTDC_BTN_SEL, UP_TEMP_F, SUF_F, 1'b0},
    '{`CTDC_BTN_SEL, UP_TEMP_C, SUF_C, 1'b0},
    '{`CTDC_BTN_MODE, UP_TEMP_C, SUF_C, 1'b1},
    '{`CTDC_BTN_SEL, UP_VOLT, SUF_E, 1'b1},
    '{`CTDC_BTN_MODE, UP_VOLT, SUF_E, 1'b0}};

  ////////////////////////////////////////////////////////////////////////////////
  always #5 clk_sys = ~clk_sys;

  ctdc_pilot pilot (
    .clk_sys (clk_sys),
    .btn     (btn)
  );

  ctdc_top #(
    .SEC_CYCLES  (SEC),
    .DATE_CYCLES (DATE)
  ) uut (
    .clk_sys            (clk_sys),
    .resetn             (resetn),
    .btn_readout_select (btn[`CTDC_BTN_SEL]),
    .btn_start_stop     (btn[`CTDC_BTN_SS]),
    .btn_mode           (btn[`CTDC_BTN_MODE]),
    .btn_reset_set      (btn[`CTDC_BTN_RST]),
    .upper_readout      (upper_readout),
    .upper_suffix       (upper_suffix),
    .lower_left         (lower_left),
    .lower_right        (lower_right),
    .lower_left_lit     (lower_left_lit),
    .lower_right_lit    (lower_right_lit),
    .timer_annunciator  (timer_annunciator),
    .clock_running      (clock_running)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [6:0] got, input logic [6:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask : cyc

  task automatic tap(input int idx);
    pilot.press(idx, 4);
    cyc(2);
  endtask : tap

  task automatic done(input string name);
    $display("Test %s finished", name);
  endtask : done

  task automatic in_range(input logic [6:0] v, input int lo, input int hi);
    chk({6'h00, v >= lo && v <= hi}, 7'h01);
  endtask : in_range

  task automatic results();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : results

  ////////////////////////////////////////////////////////////////////////////////
  // Cuts a hung run short.
  initial
  begin
    repeat (90000) @(posedge clk_sys);
    fails++;
    $display("Error at %0t: got %h expected %h", $time, 1'b0, 1'b1);
    results();
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (8) @(posedge clk_sys);
    #1 resetn = 1'b1;
    cyc(2);
    chk(7'(upper_readout), 7'(UP_VOLT));
    chk(7'(upper_suffix), 7'(SUF_E));
    chk({6'h00, timer_annunciator}, 7'h00);
    chk(lower_left, 7'h00);
    chk(lower_right, 7'h00);
    chk({6'h00, clock_running}, 7'h01);
    done("reset");
    foreach (rows[i])
    begin
      tap(rows[i].btn);
      chk(7'(upper_readout), 7'(rows[i].up));
      chk(7'(upper_suffix), 7'(rows[i].suf));
      chk({6'h00, timer_annunciator}, {6'h00, rows[i].ann});
    end
    done("rows");
    tap(`CTDC_BTN_SS);
    chk(lower_left, 7'h01);
    chk(lower_right, 7'h01);
    cyc(DATE - 8);
    chk(lower_left, 7'h01);
    cyc(8);
    chk(lower_left, 7'h00);
    done("date");
    tap(`CTDC_BTN_RST);
    left_dark  = 1'b0;
    right_dark = 1'b0;
    repeat (2 * SEC)
    begin
      cyc(1);
      left_dark  = left_dark | !lower_left_lit;
      right_dark = right_dark | !lower_right_lit;
    end
    chk({6'h00, left_dark}, 7'h01);
    chk({6'h00, right_dark}, 7'h00);
    tap(`CTDC_BTN_SS);
    tap(`CTDC_BTN_SS);
    chk(lower_left, 7'h03);
    tap(`CTDC_BTN_RST);
    tap(`CTDC_BTN_SS);
    chk(lower_right, 7'h02);
    tap(`CTDC_BTN_RST);
    chk(lower_left, 7'h03);
    chk(lower_right, 7'h02);
    tap(`CTDC_BTN_RST);
    tap(`CTDC_BTN_SS);
    chk(lower_left, 7'h01);
    tap(`CTDC_BTN_RST);
    tap(`CTDC_BTN_SS);
    chk(lower_right, 7'h01);
    tap(`CTDC_BTN_RST);
    chk(lower_left, 7'h01);
    cyc(61 * SEC);
    chk(lower_right, 7'h01);
    chk({6'h00, clock_running}, 7'h00);
    tap(`CTDC_BTN_SS);
    chk(lower_left, 7'h03);
    chk({6'h00, clock_running}, 7'h01);
    cyc(DATE + 5);
    repeat (6) tap(`CTDC_BTN_RST);
    chk({6'h00, clock_running}, 7'h01);
    chk(lower_left, 7'h01);
    tap(`CTDC_BTN_RST);
    tap(`CTDC_BTN_MODE);
    chk({6'h00, timer_annunciator}, 7'h00);
    chk({6'h00, lower_left_lit}, 7'h01);
    tap(`CTDC_BTN_SS);
    chk(lower_left, 7'h03);
    cyc(DATE + 5);
    done("setting");
    tap(`CTDC_BTN_MODE);
    tap(`CTDC_BTN_SS);
    cyc(5 * SEC);
    tap(`CTDC_BTN_SS);
    chk(lower_left, 7'h00);
    in_range(lower_right, 4, 6);
    cyc(5 * SEC);
    in_range(lower_right, 4, 6);
    tap(`CTDC_BTN_SS);
    tap(`CTDC_BTN_MODE);
    chk({6'h00, timer_annunciator}, 7'h00);
    cyc(10 * SEC);
    tap(`CTDC_BTN_MODE);
    tap(`CTDC_BTN_SS);
    in_range(lower_right, 15, 19);
    tap(`CTDC_BTN_RST);
    chk(lower_left, 7'h00);
    chk(lower_right, 7'h00);
    tap(`CTDC_BTN_SS);
    cyc(3600 * SEC + 40);
    chk(lower_left, 7'h01);
    chk(lower_right, 7'h00);
    done("timer");
    tap(`CTDC_BTN_SEL);
    @(posedge clk_sys);
    #1 resetn = 1'b0;
    cyc(2);
    chk(7'(upper_readout), 7'(UP_VOLT));
    chk(7'(upper_suffix), 7'(SUF_E));
    chk({6'h00, timer_annunciator}, 7'h00);
    chk(lower_left, 7'h00);
    chk({4'h0, lower_left_lit, lower_right_lit, clock_running}, 7'h07);
    @(posedge clk_sys);
    #1 resetn = 1'b1;
    cyc(2);
    chk(7'(upper_readout), 7'(UP_VOLT));
    chk(lower_right, 7'h00);
    chk({6'h00, clock_running}, 7'h01);
    tap(`CTDC_BTN_MODE);
    chk({6'h00, timer_annunciator}, 7'h01);
    chk(lower_left, 7'h00);
    chk(lower_right, 7'h00);
    done("mid reset");
    results();
  end
endmodule : ctdc_bench

// file: ctdc_btn.sv
// Button synchroniser and press detector.
`timescale 1ns/100ps
module ctdc_btn #(
  parameter int N = 4
) (
  input  wire logic         clk_sys,
  input  wire logic         resetn,
  input  wire logic [N-1:0] raw,
  ctdc_btn_if.src           bus
);
  import ctdc_pkg::*;

  for (genvar i = 0; i < N; i++)
  begin : g_btn
    logic [2:0] sync_q;
    logic [2:0] sync_d;
    logic       level_q;
    logic       level_d;

    always_comb
    begin
      sync_d  = {sync_q[1:0], raw[i]};
      level_d = (sync_q[1] == sync_q[2]) ? sync_q[2] : level_q;
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
      if (!resetn)
      begin
        sync_q  <= 3'h0;
        level_q <= 1'b0;
      end
      else
      begin
        sync_q  <= sync_d;
        level_q <= level_d;
      end
    end

    assign bus.press[i] = level_d & ~level_q;
  end
endmodule : ctdc_btn

// file: ctdc_btn_if.sv
// Press pulses passed from the button conditioner to the controller.
`timescale 1ns/100ps
interface ctdc_btn_if #(parameter int N = 4);
  logic [N-1:0] press;
  modport src (output press);
  modport snk (input press);
endinterface : ctdc_btn_if

// file: ctdc_defs.svh
// Constants for the clock, timer and readout display controller.
// Notes on behaviour
// - After power-up the upper area shows voltage before any button press.
// - Readout select steps voltage, Fahrenheit, Celsius, then back to voltage.
// - Voltage carries an E suffix; the temperatures carry F or C.
// - Start/stop in clock mode outside setting shows the date for 1.5 s.
// - Start/stop in timer mode toggles the elapsed counter run state.
// - Mode outside setting toggles the lower area between clock and timer.
// - The timer annunciator is lit in timer mode and dark in clock mode.
// - Reset/set in timer mode clears the elapsed count to 00:00.
// - Reset/set in clock mode enters setting with the month digits flashing.
// - Mode during setting abandons it and returns to normal clock operation.
// - Start/stop during setting increments the flashing digit pair.
// - Reset/set steps month, day, date, hour, minute, then time, ending setting.
// - Time of day is hours and minutes in 24-hour format.
// - Changed minutes leave the clock stopped until start/stop restarts it.
// - Unchanged minutes let timekeeping continue with no restart press.
// - Timer shows minutes:seconds in the first hour, then hours:minutes to 23:59.
// - The timer keeps counting while the clock is displayed.
`ifndef CTDC_DEFS_SVH
`define CTDC_DEFS_SVH
`define CTDC_CLK_HZ     100000000
`define CTDC_SEC_MS     1000
`define CTDC_DATE_MS    1500
`define CTDC_SEC_CYC    (`CTDC_SEC_MS * (`CTDC_CLK_HZ / 1000))
`define CTDC_DATE_CYC   (`CTDC_DATE_MS * (`CTDC_CLK_HZ / 1000))
`define CTDC_BTN_NUM    4
`define CTDC_BTN_SEL    0
`define CTDC_BTN_SS     1
`define CTDC_BTN_MODE   2
`define CTDC_BTN_RST    3
`define CTDC_ZERO       7'h00
`define CTDC_ONE        7'h01
`define CTDC_SEC_MAX    7'h3b
`define CTDC_MIN_MAX    7'h3b
`define CTDC_HOUR_MAX   7'h17
`define CTDC_MONTH_MAX  7'h0c
`define CTDC_DAYS_LONG  7'h1f
`define CTDC_DAYS_SHORT 7'h1e
`define CTDC_DAYS_FEB   7'h1c
`define CTDC_FEB        7'h02
`define CTDC_APR        7'h04
`define CTDC_JUN        7'h06
`define CTDC_SEP        7'h09
`define CTDC_NOV        7'h0b
`endif

// file: ctdc_pilot.sv
// Pilot model that presses the four front-panel buttons of the display controller.
`timescale 1ns/100ps
module ctdc_pilot (
  input  wire logic       clk_sys,
  output logic      [3:0] btn
);
  ////////////////////////////////////////////////////////////////////////////////
  // Released buttons sit low, as a pulled-down push button does.
  initial btn = 4'h0;

  ////////////////////////////////////////////////////////////////////////////////
  // Holds one button for hold cycles, then leaves it released for four cycles.
  task automatic press(input int idx, input int hold);
    @(posedge clk_sys);
    #1 btn[idx] = 1'b1;
    repeat (hold) @(posedge clk_sys);
    #1 btn[idx] = 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask : press
endmodule : ctdc_pilot

// file: ctdc_pkg.sv
// Types shared by the display controller modules.
package ctdc_pkg;
  typedef enum logic [1:0] {UP_VOLT, UP_TEMP_F, UP_TEMP_C} ctdc_upper_t;
  typedef enum logic [1:0] {SUF_E, SUF_F, SUF_C} ctdc_suffix_t;
  typedef enum logic {MODE_CLOCK, MODE_TIMER} ctdc_mode_t;
  typedef enum logic [2:0] {SET_IDLE, SET_MONTH, SET_DAY, SET_DATE, SET_HOUR,
                            SET_MIN} ctdc_set_t;
endpackage : ctdc_pkg

// file: ctdc_top.sv
// Clock, elapsed timer and upper readout control for the panel display.
`timescale 1ns/100ps
`include "ctdc_defs.svh"
module ctdc_top #(
  parameter int unsigned SEC_CYCLES  = `CTDC_SEC_CYC,
  parameter int unsigned DATE_CYCLES = `CTDC_DATE_CYC
) (
  input  wire logic                  clk_sys,
  input  wire logic                  resetn,
  input  wire logic                  btn_readout_select,
  input  wire logic                  btn_start_stop,
  input  wire logic                  btn_mode,
  input  wire logic                  btn_reset_set,
  output ctdc_pkg::ctdc_upper_t      upper_readout,
  output ctdc_pkg::ctdc_suffix_t     upper_suffix,
  output logic [6:0]                 lower_left,
  output logic [6:0]                 lower_right,
  output logic                       lower_left_lit,
  output logic                       lower_right_lit,
  output logic                       timer_annunciator,
  output logic                       clock_running
);
  import ctdc_pkg::*;

  localparam int SEC_W  = $clog2(SEC_CYCLES);
  localparam int DATE_W = $clog2(DATE_CYCLES);

  ////////////////////////////////////////////////////////////////////////////
  // Buttons.
  ctdc_btn_if #(.N(`CTDC_BTN_NUM)) bif ();
  logic press_sel;
  logic press_ss;
  logic press_mode;
  logic press_rst;

  ctdc_btn #(.N(`CTDC_BTN_NUM)) u_btn (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .raw     ({btn_reset_set, btn_mode, btn_start_stop, btn_readout_select}),
    .bus     (bif.src)
  );

  assign press_sel  = bif.press[`CTDC_BTN_SEL];
  assign press_ss   = bif.press[`CTDC_BTN_SS];
  assign press_mode = bif.press[`CTDC_BTN_MODE];
  assign press_rst  = bif.press[`CTDC_BTN_RST];

  ////////////////////////////////////////////////////////////////////////////
  // Seconds divider.
  logic [SEC_W-1:0] sec_cnt_q;
  logic [SEC_W-1:0] sec_cnt_d;
  logic             sec_tick;
  logic             blink_off;

  always_comb
  begin
    sec_tick  = (sec_cnt_q == SEC_W'(SEC_CYCLES - 1));
    sec_cnt_d = sec_tick ? '0 : sec_cnt_q + 1'b1;
    blink_off = (sec_cnt_q >= SEC_W'(SEC_CYCLES / 2));
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      sec_cnt_q <= '0;
    else
      sec_cnt_q <= sec_cnt_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Upper readout.
  ctdc_upper_t  upper_q;
  ctdc_upper_t  upper_d;
  ctdc_suffix_t suffix_q;
  ctdc_suffix_t suffix_d;

  always_comb
  begin
    upper_d = upper_q;
    if (press_sel)
    begin
      unique case (upper_q)
        UP_VOLT:   upper_d = UP_TEMP_F;
        UP_TEMP_F: upper_d = UP_TEMP_C;
        UP_TEMP_C: upper_d = UP_VOLT;
        default:   upper_d = UP_VOLT;
      endcase
    end
    unique case (upper_d)
      UP_TEMP_F: suffix_d = SUF_F;
      UP_TEMP_C: suffix_d = SUF_C;
      default:   suffix_d = SUF_E;
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      upper_q  <= UP_VOLT;
      suffix_q <= SUF_E;
    end
    else
    begin
      upper_q  <= upper_d;
      suffix_q <= suffix_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock, mode and set procedure.
  ctdc_mode_t        mode_q, mode_d;
  ctdc_set_t         set_q, set_d;
  logic              run_q, run_d;
  logic              date_act_q, date_act_d;
  logic [DATE_W-1:0] date_cnt_q, date_cnt_d;
  logic [6:0]        mon_q, mon_d, day_q, day_d;
  logic [6:0]        hr_q, hr_d, mn_q, mn_d, sc_q, sc_d;

  function automatic logic [6:0] month_days(input logic [6:0] m);
    if (m == `CTDC_FEB)
      return `CTDC_DAYS_FEB;
    else if (m == `CTDC_APR || m == `CTDC_JUN || m == `CTDC_SEP || m == `CTDC_NOV)
      return `CTDC_DAYS_SHORT;
    else
      return `CTDC_DAYS_LONG;
  endfunction : month_days

  always_comb
  begin
    mode_d     = mode_q;
    set_d      = set_q;
    run_d      = run_q;
    date_act_d = date_act_q;
    date_cnt_d = date_cnt_q;
    mon_d      = mon_q;
    day_d      = day_q;
    hr_d       = hr_q;
    mn_d       = mn_q;
    sc_d       = sc_q;
    if (run_q && sec_tick)
    begin
      if (sc_q != `CTDC_SEC_MAX)
        sc_d = sc_q + `CTDC_ONE;
      else
      begin
        sc_d = `CTDC_ZERO;
        if (mn_q != `CTDC_MIN_MAX)
          mn_d = mn_q + `CTDC_ONE;
        else
        begin
          mn_d = `CTDC_ZERO;
          if (hr_q != `CTDC_HOUR_MAX)
            hr_d = hr_q + `CTDC_ONE;
          else
          begin
            hr_d = `CTDC_ZERO;
            if (day_q < month_days(mon_q))
              day_d = day_q + `CTDC_ONE;
            else
            begin
              day_d = `CTDC_ONE;
              mon_d = (mon_q == `CTDC_MONTH_MAX) ? `CTDC_ONE : mon_q + `CTDC_ONE;
            end
          end
        end
      end
    end
    if (date_act_q)
    begin
      if (date_cnt_q == DATE_W'(DATE_CYCLES - 1))
        date_act_d = 1'b0;
      else
        date_cnt_d = date_cnt_q + 1'b1;
    end
    if (press_mode)
    begin
      if (set_q != SET_IDLE)
        set_d = SET_IDLE;
      else
        mode_d = (mode_q == MODE_CLOCK) ? MODE_TIMER : MODE_CLOCK;
    end
    else if (mode_q == MODE_CLOCK)
    begin
      if (press_ss)
      begin
        unique case (set_q)
          SET_IDLE:
          begin
            date_act_d = 1'b1;
            date_cnt_d = '0;
            run_d      = 1'b1;
          end
          SET_MONTH: mon_d = (mon_q == `CTDC_MONTH_MAX) ? `CTDC_ONE : mon_q + `CTDC_ONE;
          SET_DAY:   day_d = (day_q >= month_days(mon_q)) ? `CTDC_ONE : day_q + `CTDC_ONE;
          SET_HOUR:  hr_d = (hr_q == `CTDC_HOUR_MAX) ? `CTDC_ZERO : hr_q + `CTDC_ONE;
          SET_MIN:
          begin
            mn_d  = (mn_q == `CTDC_MIN_MAX) ? `CTDC_ZERO : mn_q + `CTDC_ONE;
            sc_d  = `CTDC_ZERO;
            run_d = 1'b0;
          end
          SET_DATE: run_d = run_q;
        endcase
      end
      if (press_rst)
      begin
        unique case (set_q)
          SET_IDLE:  set_d = SET_MONTH;
          SET_MONTH: set_d = SET_DAY;
          SET_DAY:   set_d = SET_DATE;
          SET_DATE:  set_d = SET_HOUR;
          SET_HOUR:  set_d = SET_MIN;
          SET_MIN:   set_d = SET_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      mode_q     <= MODE_CLOCK;
      set_q      <= SET_IDLE;
      run_q      <= 1'b1;
      date_act_q <= 1'b0;
      date_cnt_q <= '0;
      mon_q      <= `CTDC_ONE;
      day_q      <= `CTDC_ONE;
      hr_q       <= `CTDC_ZERO;
      mn_q       <= `CTDC_ZERO;
      sc_q       <= `CTDC_ZERO;
    end
    else
    begin
      mode_q     <= mode_d;
      set_q      <= set_d;
      run_q      <= run_d;
      date_act_q <= date_act_d;
      date_cnt_q <= date_cnt_d;
      mon_q      <= mon_d;
      day_q      <= day_d;
      hr_q       <= hr_d;
      mn_q       <= mn_d;
      sc_q       <= sc_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Elapsed timer.
  logic       trun_q, trun_d;
  logic [6:0] th_q, th_d, tm_q, tm_d, ts_q, ts_d;
  logic       t_max;

  always_comb
  begin
    trun_d = trun_q;
    th_d   = th_q;
    tm_d   = tm_q;
    ts_d   = ts_q;
    t_max  = (th_q == `CTDC_HOUR_MAX) && (tm_q == `CTDC_MIN_MAX) && (ts_q == `CTDC_SEC_MAX);
    if (trun_q && sec_tick && !t_max)
    begin
      if (ts_q != `CTDC_SEC_MAX)
        ts_d = ts_q + `CTDC_ONE;
      else
      begin
        ts_d = `CTDC_ZERO;
        if (tm_q != `CTDC_MIN_MAX)
          tm_d = tm_q + `CTDC_ONE;
        else
        begin
          tm_d = `CTDC_ZERO;
          th_d = th_q + `CTDC_ONE;
        end
      end
    end
    if (mode_q == MODE_TIMER && !press_mode)
    begin
      if (press_ss)
        trun_d = !trun_q;
      if (press_rst)
      begin
        th_d = `CTDC_ZERO;
        tm_d = `CTDC_ZERO;
        ts_d = `CTDC_ZERO;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      trun_q <= 1'b0;
      th_q   <= `CTDC_ZERO;
      tm_q   <= `CTDC_ZERO;
      ts_q   <= `CTDC_ZERO;
    end
    else
    begin
      trun_q <= trun_d;
      th_q   <= th_d;
      tm_q   <= tm_d;
      ts_q   <= ts_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Lower display.
  logic [6:0] left_d, right_d;
  logic       left_lit_d, right_lit_d, ann_d;

  always_comb
  begin
    ann_d       = (mode_q == MODE_TIMER);
    left_lit_d  = !(blink_off && (set_q == SET_MONTH || set_q == SET_HOUR));
    right_lit_d = !(blink_off && (set_q == SET_DAY || set_q == SET_MIN));
    if (mode_q == MODE_TIMER)
    begin
      left_d  = (th_q == `CTDC_ZERO) ? tm_q : th_q;
      right_d = (th_q == `CTDC_ZERO) ? ts_q : tm_q;
    end
    else if (date_act_q || set_q == SET_MONTH || set_q == SET_DAY || set_q == SET_DATE)
    begin
      left_d  = mon_q;
      right_d = day_q;
    end
    else
    begin
      left_d  = hr_q;
      right_d = mn_q;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      lower_left        <= `CTDC_ZERO;
      lower_right       <= `CTDC_ZERO;
      lower_left_lit    <= 1'b1;
      lower_right_lit   <= 1'b1;
      timer_annunciator <= 1'b0;
    end
    else
    begin
      lower_left        <= left_d;
      lower_right       <= right_d;
      lower_left_lit    <= left_lit_d;
      lower_right_lit   <= right_lit_d;
      timer_annunciator <= ann_d;
    end
  end

  assign upper_readout = upper_q;
  assign upper_suffix  = suffix_q;
  assign clock_running = run_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  logic seen_sel_q;

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      seen_sel_q <= 1'b0;
    else if (press_sel)
      seen_sel_q <= 1'b1;
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  volt_first_a: assert property (!seen_sel_q |-> upper_q == UP_VOLT)
    else $error("Upper area left voltage before any select press.");
  upper_cycle_a: assert property (press_sel && upper_q == UP_TEMP_C |=> upper_q == UP_VOLT)
    else $error("Celsius did not wrap back to voltage.");
  suffix_map_a: assert property ((upper_q == UP_VOLT) == (suffix_q == SUF_E))
    else $error("Suffix does not match the readout.");
  date_start_a: assert property (press_ss && !press_mode && mode_q == MODE_CLOCK &&
                                 set_q == SET_IDLE |=> date_act_q && run_q)
    else $error("Date display or restart missing after start/stop.");
  date_end_a: assert property ($fell(date_act_q) |-> $past(date_cnt_q) == DATE_W'(DATE_CYCLES - 1))
    else $error("Date display ended early.");
  timer_toggle_a: assert property (press_ss && !press_mode && mode_q == MODE_TIMER
                                   |=> trun_q != $past(trun_q))
    else $error("Timer run state did not toggle.");
  mode_toggle_a: assert property (press_mode && set_q == SET_IDLE |=> mode_q != $past(mode_q))
    else $error("Mode did not toggle.");
  annunc_a: assert property (##1 timer_annunciator == ($past(mode_q) == MODE_TIMER))
    else $error("Timer annunciator wrong.");
  timer_clear_a: assert property (press_rst && !press_mode && mode_q == MODE_TIMER
                                  |=> th_q == 0 && tm_q == 0 && ts_q == 0)
    else $error("Timer not cleared.");
  set_enter_a: assert property (press_rst && !press_mode && mode_q == MODE_CLOCK &&
                                set_q == SET_IDLE |=> set_q == SET_MONTH)
    else $error("Set procedure not entered.");
  set_abandon_a: assert property (press_mode && set_q != SET_IDLE
                                  |=> set_q == SET_IDLE && mode_q == MODE_CLOCK)
    else $error("Mode press did not abandon setting.");
  set_walk_a: assert property (press_rst && !press_mode && set_q == SET_DATE |=> set_q == SET_HOUR)
    else $error("Set step after date is not hour.");
  min_hold_a: assert property (press_ss && !press_mode && set_q == SET_MIN |=> !run_q [*2])
    else $error("Clock runs after minute change.");
  hour_range_a: assert property (hr_q <= `CTDC_HOUR_MAX && th_q <= `CTDC_HOUR_MAX)
    else $error("Hour out of 24-hour range.");
  timer_hold_a: assert property (t_max && !press_rst |=> t_max)
    else $error("Timer left its maximum without reset.");

  date_show_c: cover property (date_act_q ##1 !date_act_q);
  set_full_c: cover property (set_q == SET_MIN ##[1:1000] set_q == SET_IDLE && !run_q);
  timer_hour_c: cover property (trun_q && th_q == `CTDC_ONE);
endmodule : ctdc_top
